// ### rtl/ccs_pkg.sv
// Purpose: shared constants and types for the core state and rom window block
// Assumes: 8-bit data space, 12-bit program space
// Notes: all offsets are data-space byte addresses
package ccs_pkg;
	localparam int DATA_W = 8;
	localparam int PC_W = 12;
	localparam int STACK_DEPTH = 6;
	localparam int PAGE_W = 7;
	localparam int WIN_LOW_W = 6;
	localparam int ROM_ADDR_W = PAGE_W + WIN_LOW_W;
	// data-space offsets
	localparam logic [7:0] OFS_POINTER_ONE = 8'h80;
	localparam logic [7:0] OFS_POINTER_TWO = 8'h81;
	localparam logic [7:0] OFS_SHORT_SLOT_A = 8'h82;
	localparam logic [7:0] OFS_SHORT_SLOT_B = 8'h83;
	localparam logic [7:0] OFS_ROM_WINDOW_PAGE = 8'hc9;
	localparam logic [7:0] OFS_ACCUMULATOR = 8'hff;
	localparam logic [1:0] WIN_TOP_BITS = 2'h1;
	// reset values of the visible state
	localparam logic [PC_W-1:0] RESET_VECTOR = 12'hffe;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [PAGE_W-1:0] PAGE_RESET = 7'h00;
	// machine cycle timing
	localparam int CLK_PER_MCYCLE = 13;
	localparam logic [3:0] MCYCLE_LAST = 4'(CLK_PER_MCYCLE - 1);
	localparam logic [2:0] INSTR_CYCLES_2 = 3'h2;
	localparam logic [2:0] INSTR_CYCLES_4 = 3'h4;
	localparam logic [2:0] INSTR_CYCLES_5 = 3'h5;
	// program counter load sources
	typedef enum logic [2:0] {
		PC_NEXT,
		PC_JUMP,
		PC_CALL,
		PC_REL,
		PC_VECTOR,
		PC_SUB_EXIT,
		PC_IRQ_EXIT,
		PC_HOLD
	} ccs_pc_op_t;
	// flag context
	typedef enum logic [1:0] {
		CTX_MAIN,
		CTX_IRQ,
		CTX_NMI
	} ccs_ctx_t;
	// flag update kinds
	typedef enum logic [2:0] {
		FLG_NONE,
		FLG_ARITH,
		FLG_LOGIC,
		FLG_BITTEST,
		FLG_ROTATE
	} ccs_flag_op_t;
endpackage

// ### rtl/ccs_return_stack.sv
// Purpose: six-level hardware return stack outside data space
// Assumes: push and pop never asserted together
// Notes: saturates at both ends
`timescale 1ns/100ps
module ccs_return_stack (
	input wire logic clk,
	input wire logic srst,
	input wire logic push,
	input wire logic pop,
	input wire logic [ccs_pkg::PC_W-1:0] push_value,
	output logic [ccs_pkg::PC_W-1:0] top_value,
	output logic empty
);
	logic [ccs_pkg::PC_W-1:0] level [ccs_pkg::STACK_DEPTH];
	logic [2:0] depth;
	logic [2:0] next_depth;

	////////////////////////////////////////////////////////////////////////
	// depth tracking, saturating
	assign empty = (depth == 3'h0);
	assign top_value = level[0];
	assign next_depth = (push && depth != 3'(ccs_pkg::STACK_DEPTH)) ? depth + 3'h1 :
		(pop && !empty) ? depth - 3'h1 : depth;

	always_ff @(posedge clk) begin
		if (srst) begin
			depth <= 3'h0;
		end else begin
			depth <= next_depth;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// level shifting
	genvar i;
	generate
		for (i = 0; i < ccs_pkg::STACK_DEPTH; i++) begin : g_level
			always_ff @(posedge clk) begin
				if (srst) begin
					level[i] <= '0;
				end else if (push) begin
					level[i] <= (i == 0) ? push_value : level[(i == 0) ? 0 : i-1];
				end else if (pop && !empty) begin
					level[i] <= (i == ccs_pkg::STACK_DEPTH-1) ? level[i] :
						level[(i == ccs_pkg::STACK_DEPTH-1) ? i : i+1];
				end
			end
		end
	endgenerate
endmodule // ccs_return_stack

// ### rtl/ccs_core_state.sv
// Purpose: programmer-visible core state and data rom window of an 8-bit core
// Assumes: sequencer drives one-cycle strobes on machine-cycle boundaries
// Notes: data port is the internal data-space bus of the core
//
// Summary of operation
// - page register keeps bits 6..0 as upper rom address bits; bit 7 ignored.
// - page register is write only, undefined at reset, software writes it first.
// - 8-bit accumulator used by alu, also data location ffh.
// - two pointers give indirect addresses, also data locations 80h and 81h.
// - two short slots hold short direct bytes, at data locations 82h and 83h.
// - 12-bit program counter holds next rom location to fetch.
// - counter advances after fetch; relative branches add sign-extended offset to counter here.
// - counter loads jump, call, relative, vector, popped value, or plus one.
// - three carry/zero pairs, one per context, only current pair used.
// - interrupt entry selects its pair; interrupt exit restores previous pair.
// - pairs keep values across switches; each reachable only in its context.
// - carry from carry/borrow, loaded by bit test, rotated through on rotate.
// - zero set when last arithmetic or logic result is zero.
// - after reset the core runs in non-maskable context.
// - six 12-bit levels; push shifts up, counter to level one, sixth lost.
// - return loads counter from level one and shifts levels down.
// - stack saturates deep and shallow; empty return continues sequentially.
// - one machine cycle per 13 clocks; instructions take 2, 4 or 5 cycles.
// - window reads 40h..7fh fetch rom at page joined with six low bits.
`timescale 1ns/100ps
module ccs_core_state (
	input wire logic CLK,
	input wire logic SRST,
	// data-space access
	input wire logic [7:0] DATA_ADDR,
	input wire logic DATA_RD,
	input wire logic DATA_WR,
	input wire logic [7:0] DATA_WDATA,
	output logic [7:0] DATA_RDATA,
	output logic DATA_HIT,
	// program rom
	output logic [ccs_pkg::PC_W-1:0] ROM_FETCH_ADDR,
	output logic [ccs_pkg::ROM_ADDR_W-1:0] ROM_WIN_ADDR,
	output logic ROM_WIN_RD,
	input wire logic [7:0] ROM_WIN_DATA,
	// sequencer
	input wire logic INSTR_START,
	input wire logic [2:0] INSTR_CYCLES,
	output logic MCYCLE_TICK,
	output logic INSTR_DONE,
	input wire logic [2:0] PC_OP,
	input wire logic [ccs_pkg::PC_W-1:0] PC_TARGET,
	input wire logic [7:0] PC_OFFSET,
	input wire logic IRQ_ENTER,
	input wire logic NMI_ENTER,
	// alu results
	input wire logic [2:0] FLAG_OP,
	input wire logic [7:0] ALU_RESULT,
	input wire logic ALU_CARRY,
	input wire logic TEST_BIT,
	input wire logic ACC_LOAD,
	input wire logic [7:0] ACC_VALUE,
	// visible state
	output logic [7:0] ACC_OUT,
	output logic [7:0] POINTER_ONE_OUT,
	output logic [7:0] POINTER_TWO_OUT,
	output logic [7:0] SHORT_A_OUT,
	output logic [7:0] SHORT_B_OUT,
	output logic [ccs_pkg::PC_W-1:0] PC_OUT,
	output logic CARRY,
	output logic ZERO,
	output logic [1:0] CONTEXT
);
	logic [7:0] accumulator;
	logic [7:0] pointer_one;
	logic [7:0] pointer_two;
	logic [7:0] short_slot_a;
	logic [7:0] short_slot_b;
	logic [ccs_pkg::PAGE_W-1:0] rom_window_page;
	logic [ccs_pkg::PC_W-1:0] pc;
	logic [ccs_pkg::PC_W-1:0] next_pc;
	logic [3:0] div_count;
	logic [2:0] mcycle_count;
	logic busy;
	logic carry_main, zero_main, carry_irq, zero_irq, carry_nmi_ctx, zero_nmi_ctx;
	ccs_pkg::ccs_ctx_t ctx;
	ccs_pkg::ccs_ctx_t next_ctx;
	ccs_pkg::ccs_ctx_t saved_ctx;
	ccs_pkg::ccs_ctx_t saved_irq_ctx;
	logic cur_carry;
	logic cur_zero;
	logic next_carry;
	logic next_zero;
	logic flag_write;
	ccs_pkg::ccs_pc_op_t pc_op;
	ccs_pkg::ccs_flag_op_t flag_op;
	logic stack_push;
	logic stack_pop;
	logic stack_empty;
	logic [ccs_pkg::PC_W-1:0] stack_top;
	logic [ccs_pkg::PC_W-1:0] rel_sum;

	assign pc_op = ccs_pkg::ccs_pc_op_t'(PC_OP);
	assign flag_op = ccs_pkg::ccs_flag_op_t'(FLAG_OP);

	// address decode shared by read and write paths
	function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// machine cycle divider
	assign MCYCLE_TICK = (div_count == ccs_pkg::MCYCLE_LAST);
	assign INSTR_DONE = busy && MCYCLE_TICK && (mcycle_count == 3'h1);

	always_ff @(posedge CLK) begin
		if (SRST) begin
			div_count <= 4'h0;
		end else begin
			div_count <= MCYCLE_TICK ? 4'h0 : div_count + 4'h1;
		end
	end

	// instruction length counter in machine cycles
	always_ff @(posedge CLK) begin
		if (SRST) begin
			mcycle_count <= 3'h0;
			busy <= 1'b0;
		end else if (INSTR_START && !busy) begin
			mcycle_count <= (INSTR_CYCLES == ccs_pkg::INSTR_CYCLES_4 ||
				INSTR_CYCLES == ccs_pkg::INSTR_CYCLES_5) ? INSTR_CYCLES :
				ccs_pkg::INSTR_CYCLES_2;
			busy <= 1'b1;
		end else if (busy && MCYCLE_TICK) begin
			mcycle_count <= mcycle_count - 3'h1;
			busy <= (mcycle_count != 3'h1);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// data-space decode
	logic sel_acc, sel_p1, sel_p2, sel_sa, sel_sb, sel_page, sel_win;
	assign sel_acc = addr_is(DATA_ADDR, ccs_pkg::OFS_ACCUMULATOR);
	assign sel_p1 = addr_is(DATA_ADDR, ccs_pkg::OFS_POINTER_ONE);
	assign sel_p2 = addr_is(DATA_ADDR, ccs_pkg::OFS_POINTER_TWO);
	assign sel_sa = addr_is(DATA_ADDR, ccs_pkg::OFS_SHORT_SLOT_A);
	assign sel_sb = addr_is(DATA_ADDR, ccs_pkg::OFS_SHORT_SLOT_B);
	assign sel_page = addr_is(DATA_ADDR, ccs_pkg::OFS_ROM_WINDOW_PAGE);
	assign sel_win = (DATA_ADDR[7:6] == ccs_pkg::WIN_TOP_BITS);

	// window read goes straight to rom with current page
	assign ROM_WIN_ADDR = {rom_window_page, DATA_ADDR[ccs_pkg::WIN_LOW_W-1:0]};
	assign ROM_WIN_RD = DATA_RD && sel_win;

	// page register is write only, so it never answers a read
	assign DATA_HIT = (sel_acc || sel_p1 || sel_p2 || sel_sa || sel_sb || sel_win) ||
		(DATA_WR && sel_page);

	// registered read data
	always_ff @(posedge CLK) begin
		if (SRST) begin
			DATA_RDATA <= 8'h00;
		end else if (DATA_RD) begin
			DATA_RDATA <= sel_acc ? accumulator : sel_p1 ? pointer_one :
				sel_p2 ? pointer_two : sel_sa ? short_slot_a :
				sel_sb ? short_slot_b : sel_win ? ROM_WIN_DATA : 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// data registers; alu load of accumulator has priority
	always_ff @(posedge CLK) begin
		if (SRST) begin
			accumulator <= ccs_pkg::REG_RESET;
			pointer_one <= ccs_pkg::REG_RESET;
			pointer_two <= ccs_pkg::REG_RESET;
			short_slot_a <= ccs_pkg::REG_RESET;
			short_slot_b <= ccs_pkg::REG_RESET;
		end else begin
			if (ACC_LOAD) begin
				accumulator <= ACC_VALUE;
			end else if (DATA_WR && sel_acc) begin
				accumulator <= DATA_WDATA;
			end
			if (DATA_WR && sel_p1) pointer_one <= DATA_WDATA;
			if (DATA_WR && sel_p2) pointer_two <= DATA_WDATA;
			if (DATA_WR && sel_sa) short_slot_a <= DATA_WDATA;
			if (DATA_WR && sel_sb) short_slot_b <= DATA_WDATA;
		end
	end

	// page register, not cleared by reset; bit 7 dropped
	always_ff @(posedge CLK) begin
		if (DATA_WR && sel_page) begin
			rom_window_page <= DATA_WDATA[ccs_pkg::PAGE_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// program counter
	assign rel_sum = pc + {{4{PC_OFFSET[7]}}, PC_OFFSET};
	assign stack_push = (pc_op == ccs_pkg::PC_CALL) || (pc_op == ccs_pkg::PC_VECTOR &&
		(IRQ_ENTER || NMI_ENTER));
	assign stack_pop = (pc_op == ccs_pkg::PC_SUB_EXIT) || (pc_op == ccs_pkg::PC_IRQ_EXIT);

	always_comb begin
		next_pc = pc;
		unique case (pc_op)
			ccs_pkg::PC_NEXT: next_pc = pc + 12'h001;
			ccs_pkg::PC_JUMP, ccs_pkg::PC_CALL: next_pc = PC_TARGET;
			ccs_pkg::PC_REL: next_pc = rel_sum;
			ccs_pkg::PC_VECTOR: next_pc = PC_TARGET;
			ccs_pkg::PC_SUB_EXIT, ccs_pkg::PC_IRQ_EXIT: begin
				next_pc = stack_empty ? pc + 12'h001 : stack_top;
			end
			ccs_pkg::PC_HOLD: next_pc = pc;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			pc <= ccs_pkg::RESET_VECTOR;
		end else begin
			pc <= next_pc;
		end
	end

	ccs_return_stack u_stack (
		.clk(CLK),
		.srst(SRST),
		.push(stack_push),
		.pop(stack_pop),
		.push_value(pc),
		.top_value(stack_top),
		.empty(stack_empty)
	);

	////////////////////////////////////////////////////////////////////////
	// context selection
	always_comb begin
		next_ctx = ctx;
		if (NMI_ENTER) begin
			next_ctx = ccs_pkg::CTX_NMI;
		end else if (IRQ_ENTER) begin
			next_ctx = ccs_pkg::CTX_IRQ;
		end else if (pc_op == ccs_pkg::PC_IRQ_EXIT) begin
			next_ctx = (ctx == ccs_pkg::CTX_NMI) ? saved_ctx : saved_irq_ctx;
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			ctx <= ccs_pkg::CTX_NMI;
			saved_ctx <= ccs_pkg::CTX_MAIN;
			saved_irq_ctx <= ccs_pkg::CTX_MAIN;
		end else begin
			ctx <= next_ctx;
			if (NMI_ENTER) saved_ctx <= ctx;
			else if (IRQ_ENTER) saved_irq_ctx <= ctx;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// flag pairs; only the pair of the current context is seen or written
	assign cur_carry = (ctx == ccs_pkg::CTX_MAIN) ? carry_main :
		(ctx == ccs_pkg::CTX_IRQ) ? carry_irq : carry_nmi_ctx;
	assign cur_zero = (ctx == ccs_pkg::CTX_MAIN) ? zero_main :
		(ctx == ccs_pkg::CTX_IRQ) ? zero_irq : zero_nmi_ctx;
	assign flag_write = (flag_op != ccs_pkg::FLG_NONE);

	always_comb begin
		next_carry = cur_carry;
		next_zero = cur_zero;
		unique case (flag_op)
			ccs_pkg::FLG_NONE: ;
			ccs_pkg::FLG_ARITH: begin
				next_carry = ALU_CARRY;
				next_zero = (ALU_RESULT == 8'h00);
			end
			ccs_pkg::FLG_LOGIC: next_zero = (ALU_RESULT == 8'h00);
			ccs_pkg::FLG_BITTEST: next_carry = TEST_BIT;
			ccs_pkg::FLG_ROTATE: begin
				next_carry = ALU_CARRY;
				next_zero = (ALU_RESULT == 8'h00);
			end
			default: ;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			{carry_main, zero_main, carry_irq, zero_irq} <= 4'h0;
			{carry_nmi_ctx, zero_nmi_ctx} <= 2'h0;
		end else if (flag_write) begin
			if (ctx == ccs_pkg::CTX_MAIN) {carry_main, zero_main} <= {next_carry, next_zero};
			if (ctx == ccs_pkg::CTX_IRQ) {carry_irq, zero_irq} <= {next_carry, next_zero};
			if (ctx == ccs_pkg::CTX_NMI) begin
				{carry_nmi_ctx, zero_nmi_ctx} <= {next_carry, next_zero};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// visible outputs
	assign ACC_OUT = accumulator;
	assign POINTER_ONE_OUT = pointer_one;
	assign POINTER_TWO_OUT = pointer_two;
	assign SHORT_A_OUT = short_slot_a;
	assign SHORT_B_OUT = short_slot_b;
	assign PC_OUT = pc;
	assign ROM_FETCH_ADDR = pc;
	assign CARRY = cur_carry;
	assign ZERO = cur_zero;
	assign CONTEXT = ctx;
endmodule // ccs_core_state

// ### verif/ccs_core_state_asserts.sv
// Purpose: port-level checks of the core state and rom window block
// Assumes: one clock, synchronous active-high reset
// Notes: attached by bind at the foot of this file
`timescale 1ns/100ps
module ccs_core_state_chk (
	input wire logic CLK,
	input wire logic SRST,
	input wire logic [7:0] DATA_ADDR,
	input wire logic DATA_RD,
	input wire logic DATA_WR,
	input wire logic [7:0] DATA_WDATA,
	input wire logic [7:0] DATA_RDATA,
	input wire logic [ccs_pkg::ROM_ADDR_W-1:0] ROM_WIN_ADDR,
	input wire logic ROM_WIN_RD,
	input wire logic [7:0] ROM_WIN_DATA,
	input wire logic MCYCLE_TICK,
	input wire logic [2:0] PC_OP,
	input wire logic [ccs_pkg::PC_W-1:0] PC_TARGET,
	input wire logic [ccs_pkg::PC_W-1:0] PC_OUT,
	input wire logic IRQ_ENTER,
	input wire logic NMI_ENTER,
	input wire logic [2:0] FLAG_OP,
	input wire logic [7:0] ALU_RESULT,
	input wire logic ALU_CARRY,
	input wire logic [7:0] POINTER_ONE_OUT,
	input wire logic CARRY,
	input wire logic ZERO,
	input wire logic [1:0] CONTEXT
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SRST);
	////////////////////////////////////////////////////////////////////////
	// quiet gap after each machine-cycle tick, first eight then four more clocks
	sequence s_tick_gap;
		##1 !MCYCLE_TICK [*8];
	endsequence
	sequence s_tick_tail;
		##1 !MCYCLE_TICK [*4] ##1 MCYCLE_TICK;
	endsequence
	wire plain_arith = FLAG_OP == 3'h1 && !IRQ_ENTER && !NMI_ENTER && PC_OP != 3'h6;
	////////////////////////////////////////////////////////////////////////
	chk_win_addr_join: assert property (
		DATA_RD && DATA_ADDR[7:6] == 2'h1 |-> ROM_WIN_RD && ROM_WIN_ADDR[5:0] == DATA_ADDR[5:0])
		else $error("window address not joined from data address");
	chk_win_rdata: assert property (
		ROM_WIN_RD |=> DATA_RDATA == $past(ROM_WIN_DATA))
		else $error("window read data not returned");
	chk_pointer_write: assert property (
		DATA_WR && DATA_ADDR == 8'h80 |=> POINTER_ONE_OUT == $past(DATA_WDATA))
		else $error("pointer write lost");
	chk_pc_step: assert property (
		PC_OP == 3'h0 |=> PC_OUT == $past(PC_OUT) + 12'h001)
		else $error("counter did not step by one");
	chk_pc_jump: assert property (
		PC_OP == 3'h1 |=> PC_OUT == $past(PC_TARGET))
		else $error("counter did not load jump target");
	chk_tick_period: assert property (
		MCYCLE_TICK |-> s_tick_gap ##0 s_tick_tail)
		else $error("machine cycle period wrong");
	chk_nmi_enter: assert property (
		NMI_ENTER |=> CONTEXT == 2'h2)
		else $error("nmi context not entered");
	chk_reset_ctx: assert property (
		$fell(SRST) |-> CONTEXT == 2'h2)
		else $error("context after reset not nmi");
	chk_zero_arith: assert property (
		plain_arith |=> ZERO == ($past(ALU_RESULT) == 8'h00))
		else $error("zero flag wrong after arithmetic");
	chk_carry_arith: assert property (
		plain_arith |=> CARRY == $past(ALU_CARRY))
		else $error("carry flag wrong after arithmetic");
endmodule // ccs_core_state_chk

bind ccs_core_state ccs_core_state_chk i_chk (.CLK(CLK), .SRST(SRST), .DATA_ADDR(DATA_ADDR),
	.DATA_RD(DATA_RD), .DATA_WR(DATA_WR), .DATA_WDATA(DATA_WDATA), .DATA_RDATA(DATA_RDATA),
	.ROM_WIN_ADDR(ROM_WIN_ADDR), .ROM_WIN_RD(ROM_WIN_RD), .ROM_WIN_DATA(ROM_WIN_DATA),
	.MCYCLE_TICK(MCYCLE_TICK), .PC_OP(PC_OP), .PC_TARGET(PC_TARGET), .PC_OUT(PC_OUT),
	.IRQ_ENTER(IRQ_ENTER), .NMI_ENTER(NMI_ENTER), .FLAG_OP(FLAG_OP), .ALU_RESULT(ALU_RESULT),
	.ALU_CARRY(ALU_CARRY), .POINTER_ONE_OUT(POINTER_ONE_OUT), .CARRY(CARRY), .ZERO(ZERO),
	.CONTEXT(CONTEXT));

// ### verif/ccs_rom_model.sv
// Purpose: program rom seen through the data window
// Assumes: byte content is a fixed mix of the address bits
// Notes: outside a window read the data lines carry a changing pattern
`timescale 1ns/100ps
module ccs_rom_model (
	input wire logic [ccs_pkg::ROM_ADDR_W-1:0] addr,
	input wire logic rd,
	output logic [7:0] data
);
	// idle lines show the inverse address so a stale byte never looks valid
	assign data = rd ? (addr[7:0] ^ {1'b0, addr[12:6]}) : ~addr[7:0];
endmodule // ccs_rom_model

// ### verif/cpu_core_state_and_rom_window_test.sv
// Purpose: self-checking bench for the core state and rom window block
// Assumes: inputs driven at the falling clock edge
// Notes: tasks start and end on a falling edge
`timescale 1ns/100ps
module cpu_core_state_and_rom_window_test;
	logic CLK = 0, SRST = 1, DATA_RD = 0, DATA_WR = 0, ACC_LOAD = 0;
	logic INSTR_START = 0, IRQ_ENTER = 0, NMI_ENTER = 0, ALU_CARRY = 0, TEST_BIT = 0;
	logic [7:0] DATA_ADDR = 0, DATA_WDATA = 0, PC_OFFSET = 0, ALU_RESULT = 0, ACC_VALUE = 0;
	logic [7:0] rdata, acc, p1, p2, sa, sb, rdat;
	logic [2:0] INSTR_CYCLES = 0, PC_OP = 3'h7, FLAG_OP = 0;
	logic [11:0] PC_TARGET = 0, fetch, pc;
	logic [12:0] waddr;
	logic whit, wrd, tick, done, cy, zr;
	logic [1:0] ctx;
	int n_errors = 0, checks = 0, cycles = 0, n, k;
	////////////////////////////////////////////////////////////////////////
	ccs_core_state i_ccs_core_state (.CLK(CLK), .SRST(SRST), .DATA_ADDR(DATA_ADDR),
		.DATA_RD(DATA_RD), .DATA_WR(DATA_WR), .DATA_WDATA(DATA_WDATA), .DATA_RDATA(rdata),
		.DATA_HIT(whit), .ROM_FETCH_ADDR(fetch), .ROM_WIN_ADDR(waddr), .ROM_WIN_RD(wrd),
		.ROM_WIN_DATA(rdat), .INSTR_START(INSTR_START), .INSTR_CYCLES(INSTR_CYCLES),
		.MCYCLE_TICK(tick), .INSTR_DONE(done), .PC_OP(PC_OP), .PC_TARGET(PC_TARGET),
		.PC_OFFSET(PC_OFFSET), .IRQ_ENTER(IRQ_ENTER), .NMI_ENTER(NMI_ENTER), .FLAG_OP(FLAG_OP),
		.ALU_RESULT(ALU_RESULT), .ALU_CARRY(ALU_CARRY), .TEST_BIT(TEST_BIT),
		.ACC_LOAD(ACC_LOAD), .ACC_VALUE(ACC_VALUE), .ACC_OUT(acc), .POINTER_ONE_OUT(p1),
		.POINTER_TWO_OUT(p2), .SHORT_A_OUT(sa), .SHORT_B_OUT(sb), .PC_OUT(pc), .CARRY(cy),
		.ZERO(zr), .CONTEXT(ctx));
	ccs_rom_model i_ccs_rom_model (.addr(waddr), .rd(wrd), .data(rdat));
	////////////////////////////////////////////////////////////////////////
	// clock and hang guard
	initial begin
		forever #2 CLK = ~CLK;
	end
	always @(posedge CLK) begin
		cycles++;
		if (cycles == 3000) begin
			n_errors++;
			final_report();
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
			n_errors++;
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		DATA_ADDR = a;
		DATA_WDATA = d;
		DATA_WR = 1;
		@(negedge CLK);
		DATA_WR = 0;
		@(negedge CLK);
	endtask
	task automatic rd(logic [7:0] a, output logic [7:0] d);
		DATA_ADDR = a;
		DATA_RD = 1;
		@(negedge CLK);
		DATA_RD = 0;
		d = rdata;
		@(negedge CLK);
	endtask
	task automatic pcop(logic [2:0] op, logic [11:0] t, logic irq);
		PC_OP = op;
		PC_TARGET = t;
		IRQ_ENTER = irq;
		@(negedge CLK);
		PC_OP = 3'h7;
		IRQ_ENTER = 0;
		@(negedge CLK);
	endtask
	task automatic flag(logic [2:0] op, logic [7:0] r, logic c, logic b);
		FLAG_OP = op;
		ALU_RESULT = r;
		ALU_CARRY = c;
		TEST_BIT = b;
		@(negedge CLK);
		FLAG_OP = 0;
		@(negedge CLK);
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		logic [7:0] v;
		logic [7:0] ofs [5] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hff};
		repeat (6) @(negedge CLK);
		SRST = 0;
		check("pc reset", pc, ccs_pkg::RESET_VECTOR);
		check("reset ctx", ctx, 2'h2);
		$display("test reset done");
		foreach (ofs[i]) wr(ofs[i], 8'h5a + 8'(i));
		foreach (ofs[i]) begin
			rd(ofs[i], v);
			check("reg", v, 8'h5a + 8'(i));
		end
		check("acc out", acc, 8'h5e);
		check("acc hit", 16'(whit), 16'h0001);
		check("pointers out", {p1, p2}, 16'h5a5b);
		check("short out", {sa, sb}, 16'h5c5d);
		// page register is never read; only its address decode is looked at
		DATA_ADDR = 8'hc9;
		@(negedge CLK);
		check("page hit", 16'(whit), 16'h0000);
		rd(8'h90, v);
		check("unmapped", v, 8'h00);
		check("unmapped hit", 16'(whit), 16'h0000);
		ACC_VALUE = 8'h3c;
		ACC_LOAD = 1;
		@(negedge CLK);
		ACC_LOAD = 0;
		check("acc load", acc, 8'h3c);
		$display("test registers done");
		// page written at start-up, before any interrupt handler runs
		wr(8'hc9, 8'hb5);
		rd(8'h7f, v);
		check("win b5", v, 8'h7f ^ 8'h35);
		wr(8'hc9, 8'h02);
		rd(8'h40, v);
		check("win 02", v, 8'h80 ^ 8'h02);
		$display("test window done");
		pcop(3'h1, 12'h050, 0);
		PC_OFFSET = 8'hfe;
		pcop(3'h3, 0, 0);
		check("rel", pc, 12'h04e);
		pcop(3'h0, 0, 0);
		check("next", pc, 12'h04f);
		check("fetch addr", 16'(fetch), 16'h004f);
		pcop(3'h1, 12'h000, 0);
		for (int i = 1; i <= 7; i++) pcop(3'h2, 12'(i * 256), 0);
		for (int i = 6; i >= 1; i--) begin
			pcop(3'h5, 0, 0);
			check("pop", pc, 12'(i * 256));
		end
		pcop(3'h5, 0, 0);
		check("empty pop", pc, 12'h101);
		$display("test counter done");
		flag(3'h1, 8'h00, 1, 0);
		check("nmi cz", {cy, zr}, 2'h3);
		pcop(3'h4, 12'h010, 1);
		check("irq ctx", ctx, 2'h1);
		check("irq cz", {cy, zr}, 2'h0);
		flag(3'h2, 8'h05, 1, 0);
		check("logic", {cy, zr}, 2'h0);
		flag(3'h3, 8'h00, 0, 1);
		check("bittest", {cy, zr}, 2'h2);
		flag(3'h4, 8'h00, 0, 0);
		check("rotate", {cy, zr}, 2'h1);
		pcop(3'h6, 0, 0);
		check("exit ctx", ctx, 2'h2);
		check("kept cz", {cy, zr}, 2'h3);
		check("irq ret", pc, 12'h101);
		// leave nmi context for main, then enter nmi again from main
		pcop(3'h6, 0, 0);
		check("main ctx", 16'(ctx), 16'h0000);
		check("main cz", 16'({cy, zr}), 16'h0000);
		flag(3'h1, 8'h00, 0, 0);
		NMI_ENTER = 1;
		@(negedge CLK);
		NMI_ENTER = 0;
		check("nmi again", 16'({cy, zr}), 16'h0003);
		pcop(3'h6, 0, 0);
		check("main kept", 16'({cy, zr}), 16'h0001);
		$display("test flags done");
		for (int c = 0; c < 4; c++) begin
			while (tick !== 1'b1) @(negedge CLK);
			@(negedge CLK);
			INSTR_CYCLES = c == 0 ? ccs_pkg::INSTR_CYCLES_2 : c == 3 ? 3'h3 : 3'(c + 3);
			INSTR_START = 1;
			@(negedge CLK);
			INSTR_START = 0;
			n = 1;
			for (k = 0; k < 100 && done !== 1'b1; k++) begin
				n += int'(tick);
				@(negedge CLK);
			end
			check("instr ticks", 16'(n), c == 3 ? 16'h0002 : 16'(INSTR_CYCLES));
		end
		$display("test timing done");
		final_report();
	end
endmodule // cpu_core_state_and_rom_window_test
